// *** pkg/hq_mode_pkg.sv ***
// Constants, encodings and band tables for the mode classifier and band grouper
package hq_mode_pkg;

	// ***********************************************************
	// Encodings
	// ***********************************************************
	typedef enum logic [1:0] {BW_NB, BW_WB, BW_SWB, BW_FB} bw_e;
	typedef enum logic [1:0] {RATE_7K2, RATE_8K0, RATE_13K2, RATE_16K4} rate_e;

	// ***********************************************************
	// Register map (byte addresses)
	// ***********************************************************
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_BANDS  = 8'h08;
	localparam logic [7:0] OFS_COUNTS = 8'h0C;
	localparam int         CTRL_BW_LSB   = 0;
	localparam int         CTRL_RATE_LSB = 2;
	localparam logic [1:0] CTRL_BW_RST   = 2'h0;
	localparam logic [1:0] CTRL_RATE_RST = 2'h0;

	// ***********************************************************
	// Sharpness analysis
	// ***********************************************************
	localparam int          MAG_W       = 16;
	localparam int          SUM_W       = MAG_W + 5;
	localparam int          CMP_W       = SUM_W + 6;
	localparam int          IDX_W       = 10;
	localparam int          SUBBAND_LOG = 5;
	localparam logic [4:0]  SUBBAND_LAST = 5'h1F;
	localparam logic [4:0]  J_FIRST     = 5'h03;
	localparam logic [4:0]  J_LOW_LAST  = 5'h07;
	localparam logic [4:0]  J_LAST      = 5'h10;
	// Sharp > 4.5  <=>  2*32*max > 9*sum ; Sharp > 3.6  <=>  5*32*max > 18*sum
	localparam logic [CMP_W-1:0] LOW_MAX_MUL  = 27'h0000040;
	localparam logic [CMP_W-1:0] LOW_SUM_MUL  = 27'h0000009;
	localparam logic [CMP_W-1:0] HIGH_MAX_MUL = 27'h00000A0;
	localparam logic [CMP_W-1:0] HIGH_SUM_MUL = 27'h0000012;
	localparam logic [MAG_W-1:0] PEAK_MIN     = 16'h000A;
	localparam logic [3:0] TOTAL_MIN   = 4'hA;
	localparam logic [3:0] HIGH_MIN    = 4'h5;
	localparam logic [3:0] VOTE_MAX    = 4'h8;
	localparam logic [3:0] VOTE_MIN    = 4'h0;
	localparam logic [3:0] VOTE_THR    = 4'h5;
	localparam logic [2:0] SHORT_BLOCKS = 3'h4;
	localparam logic [2:0] LONG_BLOCKS  = 3'h1;

	// ***********************************************************
	// Band partition lookup: {transient bands, normal bands, coefficients}
	// ***********************************************************
	function automatic logic [5:0] band_count(input bw_e bw, input rate_e rate, input logic transient);
		logic hi;
		hi = (rate == RATE_13K2) || (rate == RATE_16K4);
		case (bw)
			BW_NB:   band_count = transient ? (hi ? 6'h14 : 6'h10) : (hi ? 6'h13 : 6'h0D);
			BW_WB:   band_count = transient ? ((rate == RATE_16K4) ? 6'h1C : 6'h14)
			                                : ((rate == RATE_16K4) ? 6'h14 : 6'h12);
			default: band_count = transient ? 6'h20 : ((rate == RATE_16K4) ? 6'h18 : 6'h16);
		endcase
	endfunction

	function automatic logic [9:0] band_span(input bw_e bw, input rate_e rate);
		case (bw)
			BW_NB:   band_span = 10'h0A0;
			BW_WB:   band_span = 10'h140;
			default: band_span = (rate == RATE_16K4) ? 10'h280 : 10'h238;
		endcase
	endfunction

endpackage

// *** logic/band_peak_acc.sv ***
// Peak and magnitude-sum accumulator over one 32-coefficient sub-band
`timescale 1ns/1ps
module band_peak_acc
	import hq_mode_pkg::*;
(
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Coefficient stream
	input  wire logic             in_valid,
	input  wire logic             in_first,
	input  wire logic             in_last,
	input  wire logic [MAG_W-1:0] in_mag,
	// Band result
	output logic                  done_q,
	output logic [MAG_W-1:0]      max_q,
	output logic [SUM_W-1:0]      sum_q
);

	typedef struct packed {
		logic             done;
		logic [MAG_W-1:0] run_max;
		logic [SUM_W-1:0] run_sum;
		logic [MAG_W-1:0] max;
		logic [SUM_W-1:0] sum;
	} acc_s;

	acc_s s_q;
	acc_s s_d;

	always_comb begin
		logic [MAG_W-1:0] m;
		logic [SUM_W-1:0] t;
		m = '0;
		t = '0;
		s_d = s_q;
		s_d.done = 1'b0;
		if (in_valid) begin
			m = in_first ? '0 : s_q.run_max;
			t = in_first ? '0 : s_q.run_sum;
			m = (in_mag > m) ? in_mag : m;
			t = t + SUM_W'(in_mag);
			s_d.run_max = m;
			s_d.run_sum = t;
			if (in_last) begin
				s_d.done = 1'b1;
				s_d.max  = m;
				s_d.sum  = t;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done_q = s_q.done;
	assign max_q  = s_q.max;
	assign sum_q  = s_q.sum;

endmodule // band_peak_acc

// *** logic/hq_mode_classifier.sv ***
// Frame mode classifier and band grouper with APB register access
// Operation
// - SWB/FB at 13.2 or 16.4 kbps choose transient, normal or harmonic per frame.
// - NB/WB skip tonality estimation; choose transient or normal only.
// - Mode leaves as two bits: transient flag and harmonic flag.
// - NB/WB non-transient frames are always normal, never harmonic.
// - Tonality uses coefficients 96..543 as 14 sub-bands of 32, j = 3..16.
// - Peakiness is 32*peak/sum; zero sum gives zero peakiness.
// - Sub-band peak is the largest magnitude over 32j..32j+31.
// - Low count, cleared per frame, counts j 3..7 with peakiness above 4.5.
// - High count counts j 8..16 with peakiness above 3.6 and peak above 10.
// - Total at least 10 and high above 5 raises harmonic vote, else lowers.
// - Both votes start at zero and saturate between 0 and 8.
// - Harmonic if non-harmonic vote below 5 with condition, or harmonic vote >= 5.
// - Partition follows bandwidth: NB, WB, and SWB for both SWB and FB.
// - FB at the higher rates uses the SWB band count and boundaries.
// - Transient frames group four concatenated short-block spectra as one vector.
// - Band count depends on bandwidth, bitrate and mode.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
module hq_mode_classifier
	import hq_mode_pkg::*;
#(
	parameter int ADDR_W = 8
)(
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// Coefficient magnitudes from the transform stage
	input  wire logic              coef_valid,
	input  wire logic [MAG_W-1:0]  coef_mag,
	input  wire logic              coef_last,
	input  wire logic              frame_transient,
	// Mode and partition to the envelope stage
	output logic                   mode_transient,
	output logic                   mode_harmonic,
	output logic [5:0]             band_total,
	output logic [9:0]             coef_total,
	output logic [2:0]             short_blocks,
	output logic                   frame_done
);

	// ***********************************************************
	// Local constants
	// ***********************************************************
	// Only the low address byte is decoded; a wider bus sees the map repeat.
	localparam int                     DEC_MSB      = 7;
	localparam logic [SUBBAND_LOG-1:0] SUBBAND_ZERO = '0;

	// ***********************************************************
	// State
	// ***********************************************************
	typedef struct packed {
		// Control register
		bw_e              bw;
		rate_e            rate;
		// APB response
		logic             ready;
		logic [31:0]      rdata;
		logic             slverr;
		// Stream position and per-frame counts
		logic [IDX_W-1:0] idx;
		logic [4:0]       band_j;
		logic [2:0]       low_cnt;
		logic [3:0]       high_cnt;
		// Votes, kept from frame to frame
		logic [3:0]       harm_vote;
		logic [3:0]       nonharmonic_vote;
		// Decision pipeline
		logic             last1;
		logic             last2;
		logic             trans_pend;
		// Published frame result
		logic             transient;
		logic             harmonic;
		logic [5:0]       bands;
		logic [9:0]       span;
		logic [2:0]       blocks;
		logic             done;
	} top_s;

	top_s s_q;
	top_s s_d;

	logic             acc_done;
	logic [MAG_W-1:0] acc_max;
	logic [SUM_W-1:0] acc_sum;
	logic             in_range;
	logic             sub_first;
	logic             sub_last;

	// ***********************************************************
	// Sub-band window
	// ***********************************************************
	// The index runs straight through the frame, so the four short spectra of a
	// transient frame are one vector with no restart between them.
	// Coefficients outside j = 3..16 never reach the accumulator.
	assign in_range  = (s_q.idx[IDX_W-1:SUBBAND_LOG] >= J_FIRST)
	                && (s_q.idx[IDX_W-1:SUBBAND_LOG] <= J_LAST);
	assign sub_first = in_range && (s_q.idx[SUBBAND_LOG-1:0] == SUBBAND_ZERO);
	assign sub_last  = in_range && (s_q.idx[SUBBAND_LOG-1:0] == SUBBAND_LAST);

	// Peak and sum of a sub-band appear one cycle after its last coefficient
	band_peak_acc u_acc (
		.pclk     (pclk),
		.presetn  (presetn),
		.in_valid (coef_valid && in_range),
		.in_first (sub_first),
		.in_last  (sub_last),
		.in_mag   (coef_mag),
		.done_q   (acc_done),
		.max_q    (acc_max),
		.sum_q    (acc_sum)
	);

	// ***********************************************************
	// Next state
	// ***********************************************************
	always_comb begin
		logic [CMP_W-1:0] pk;
		logic [CMP_W-1:0] sm;
		logic             sharp_l;
		logic             sharp_h;
		logic [4:0]       total;
		logic             cond;
		logic             tonal;
		logic [3:0]       hv;
		logic [3:0]       nv;
		logic [31:0]      rd;
		logic             hit;
		pk      = CMP_W'(acc_max);
		sm      = CMP_W'(acc_sum);
		sharp_l = 1'b0;
		sharp_h = 1'b0;
		total   = 5'h00;
		cond    = 1'b0;
		tonal   = 1'b0;
		hv      = s_q.harm_vote;
		nv      = s_q.nonharmonic_vote;
		rd      = 32'h00000000;
		hit     = 1'b1;
		s_d      = s_q;
		s_d.done = 1'b0;

		// ***********************************************************
		// Stream bookkeeping
		// ***********************************************************
		// The index restarts on coef_last even in mid sub-band, so a short frame
		// leaves no partial band behind for the next one.
		if (coef_valid) begin
			s_d.idx = coef_last ? '0 : s_q.idx + IDX_W'(1);
			if (sub_last) begin
				s_d.band_j = s_q.idx[IDX_W-1:SUBBAND_LOG];
			end
			// The transient flag rides with the last coefficient until the decision
			if (coef_last) begin
				s_d.trans_pend = frame_transient;
			end
		end
		s_d.last1 = coef_valid && coef_last;
		s_d.last2 = s_q.last1;

		// ***********************************************************
		// Sub-band sharpness counts
		// ***********************************************************
		// A zero sum forces a zero peak, so both sides are zero and the test fails,
		// which is the zero-peakiness answer without a divider. The products stay
		// below 2^27 for any 16-bit magnitude, so nothing wraps.
		sharp_l = (pk * LOW_MAX_MUL) > (sm * LOW_SUM_MUL);
		sharp_h = (pk * HIGH_MAX_MUL) > (sm * HIGH_SUM_MUL);
		if (acc_done) begin
			if (s_q.band_j <= J_LOW_LAST) begin
				if (sharp_l) begin
					s_d.low_cnt = s_q.low_cnt + 3'h1;
				end
			end else if (sharp_h && (acc_max > PEAK_MIN)) begin
				s_d.high_cnt = s_q.high_cnt + 4'h1;
			end
		end

		// ***********************************************************
		// Vote update
		// ***********************************************************
		// Worked out every cycle and stored only at the frame decision, two cycles
		// after the last coefficient, so the final sub-band has been counted.
		total = 5'(s_q.low_cnt) + 5'(s_q.high_cnt);
		cond  = (total >= 5'(TOTAL_MIN)) && (s_q.high_cnt > HIGH_MIN);
		// Tonality runs only for the wide bandwidths at the two higher rates
		tonal = ((s_q.bw == BW_SWB) || (s_q.bw == BW_FB))
		     && ((s_q.rate == RATE_13K2) || (s_q.rate == RATE_16K4));
		if (cond) begin
			hv = (s_q.harm_vote < VOTE_MAX) ? s_q.harm_vote + 4'h1 : s_q.harm_vote;
			nv = (s_q.nonharmonic_vote > VOTE_MIN) ? s_q.nonharmonic_vote - 4'h1 : s_q.nonharmonic_vote;
		end else begin
			hv = (s_q.harm_vote > VOTE_MIN) ? s_q.harm_vote - 4'h1 : s_q.harm_vote;
			nv = (s_q.nonharmonic_vote < VOTE_MAX) ? s_q.nonharmonic_vote + 4'h1 : s_q.nonharmonic_vote;
		end

		// ***********************************************************
		// Frame decision
		// ***********************************************************
		// Frames that can never be harmonic leave both votes alone, so a switch of
		// bandwidth or rate does not drain what earlier frames built up.
		if (s_q.last2) begin
			s_d.done      = 1'b1;
			s_d.low_cnt   = 3'h0;
			s_d.high_cnt  = 4'h0;
			s_d.transient = s_q.trans_pend;
			s_d.harmonic  = 1'b0;
			if (!s_q.trans_pend && tonal) begin
				s_d.harm_vote        = hv;
				s_d.nonharmonic_vote = nv;
				s_d.harmonic = ((nv < VOTE_THR) && cond) || (hv >= VOTE_THR);
			end
			// FB shares the SWB rows of the lookup
			s_d.bands  = band_count(s_q.bw, s_q.rate, s_q.trans_pend);
			s_d.span   = band_span(s_q.bw, s_q.rate);
			s_d.blocks = s_q.trans_pend ? SHORT_BLOCKS : LONG_BLOCKS;
		end

		// ***********************************************************
		// Register read decode
		// ***********************************************************
		case (paddr[DEC_MSB:0])
			OFS_CTRL:   rd = {28'h0000000, s_q.rate, s_q.bw};
			OFS_STATUS: rd = {16'h0000,
			                  4'(s_q.nonharmonic_vote),
			                  s_q.harm_vote,
			                  5'h00,
			                  s_q.blocks == SHORT_BLOCKS,
			                  s_q.harmonic,
			                  s_q.transient};
			OFS_BANDS:  rd = {16'h0000, s_q.bands, s_q.span};
			OFS_COUNTS: rd = {24'h000000, 1'b0, s_q.low_cnt, s_q.high_cnt};
			default: begin
				rd  = 32'h00000000;
				hit = 1'b0;
			end
		endcase

		// ***********************************************************
		// APB handshake
		// ***********************************************************
		// One wait state, so pready, prdata and pslverr all leave straight from
		// flops; the cost is one extra cycle on every access.
		if (psel && penable && s_q.ready) begin
			s_d.ready  = 1'b0;
			s_d.slverr = 1'b0;
			if (pwrite && hit && (paddr[DEC_MSB:0] == OFS_CTRL)) begin
				s_d.bw   = bw_e'(pwdata[CTRL_BW_LSB +: 2]);
				s_d.rate = rate_e'(pwdata[CTRL_RATE_LSB +: 2]);
			end
		end else if (psel && penable) begin
			// Writes answer with zero data; an unmapped address is flagged, never applied
			s_d.ready  = 1'b1;
			s_d.rdata  = pwrite ? 32'h00000000 : rd;
			s_d.slverr = !hit;
		end else begin
			s_d.ready  = 1'b0;
			s_d.slverr = 1'b0;
		end
	end

	// ***********************************************************
	// Registers
	// ***********************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Reset is asynchronous; control comes back as narrowband at the
			// lowest rate, with one block per frame
			s_q      <= '0;
			s_q.bw   <= bw_e'(CTRL_BW_RST);
			s_q.rate <= rate_e'(CTRL_RATE_RST);
			s_q.blocks <= LONG_BLOCKS;
		end else begin
			s_q <= s_d;
		end
	end

	// ***********************************************************
	// Outputs
	// ***********************************************************
	assign pready         = s_q.ready;
	assign prdata         = s_q.rdata;
	assign pslverr        = s_q.slverr;
	assign mode_transient = s_q.transient;
	assign mode_harmonic  = s_q.harmonic;
	assign band_total     = s_q.bands;
	assign coef_total     = s_q.span;
	assign short_blocks   = s_q.blocks;
	assign frame_done     = s_q.done;

endmodule // hq_mode_classifier

// *** tb/hq_mode_properties.sv ***
// Port checker for the mode classifier and band grouper
`timescale 1ns/1ps
module hq_mode_checker
	import hq_mode_pkg::*;
#(
	parameter int ADDR_W = 8
)(
	// Clock, reset and APB
	input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	// Coefficient stream
	input wire logic coef_valid, coef_last, frame_transient,
	input wire logic [MAG_W-1:0] coef_mag,
	// Mode and partition
	input wire logic mode_transient, mode_harmonic, frame_done,
	input wire logic [5:0] band_total,
	input wire logic [9:0] coef_total,
	input wire logic [2:0] short_blocks
);
	// ***********************************************************
	// Properties
	// ***********************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	mode_bits_a: assert property (mode_harmonic |-> !mode_transient) else $error("harmonic with transient");
	narrow_normal_a: assert property (mode_harmonic |-> band_total inside {6'h16, 6'h18})
		else $error("harmonic outside wide partition");
	short_blk_a: assert property (frame_done |-> short_blocks == (mode_transient ? 3'h4 : 3'h1))
		else $error("short block count wrong");
	wide_trans_a: assert property (frame_done && mode_transient && coef_total > 10'h140 |-> band_total == 6'h20)
		else $error("wide transient band count wrong");
	span_set_a: assert property (frame_done |-> coef_total inside {10'h0A0, 10'h140, 10'h238, 10'h280})
		else $error("partition span unknown");
	done_delay_a: assert property (coef_valid && coef_last |-> ##3 frame_done) else $error("frame_done late");
	trans_follow_a: assert property (coef_valid && coef_last |-> ##3 mode_transient == $past(frame_transient, 3))
		else $error("transient bit wrong");
	mode_hold_a: assert property (!frame_done |-> $stable({mode_transient, mode_harmonic, band_total, coef_total}))
		else $error("mode changed between frames");
	done_pulse_a: assert property (frame_done |=> !frame_done) else $error("frame_done too long");
	cover property (frame_done && mode_harmonic);
	cover property (frame_done && mode_transient);
	cover property (pready && pslverr);
endmodule // hq_mode_checker

bind hq_mode_classifier hq_mode_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// *** tb/coef_source.sv ***
// Transform stage model: streams one frame of coefficient magnitudes
`timescale 1ns/1ps
module coef_source
	import hq_mode_pkg::*;
(
	// Clock
	input  wire logic         pclk,
	// Coefficient stream
	output logic              coef_valid,
	output logic [MAG_W-1:0]  coef_mag,
	output logic              coef_last,
	output logic              frame_transient
);
	initial begin
		coef_valid = 1'b0;
		coef_mag = 16'hA5A5;
		coef_last = 1'b0;
		frame_transient = 1'b0;
	end
	// One spike per sub-band over a floor; idle data toggles so stale values never look valid
	task automatic send(input logic [MAG_W-1:0] spk, bg, input logic tr);
		for (int k = 0; k < 544; k++) begin
			@(posedge pclk);
			coef_valid <= 1'b1;
			coef_mag <= (k[4:0] == 5'(k[9:5] % 7)) ? spk : bg;
			coef_last <= (k == 543);
			frame_transient <= tr;
		end
		@(posedge pclk);
		coef_valid <= 1'b0;
		coef_last <= 1'b0;
		coef_mag <= ~coef_mag;
		frame_transient <= ~tr;
	endtask
endmodule // coef_source

// *** tb/tb_hq_mode_classifier.sv ***
// Self-checking bench for the mode classifier and band grouper
`timescale 1ns/1ps
module tb_hq_mode_classifier;
	import hq_mode_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, harm;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, coef_valid, coef_last, frame_transient, mode_transient, mode_harmonic, frame_done;
	logic [MAG_W-1:0] coef_mag;
	logic [5:0] band_total;
	logic [9:0] coef_total;
	logic [2:0] short_blocks;
	logic [3:0] hv, nv;
	logic [18:0] pe;
	int err_count = 0, cmp_count = 0;
	always #20 pclk = ~pclk;
	coef_source src (.*);
	hq_mode_classifier #(.ADDR_W(8)) DUT (.*);
	// ***********************************************************
	// Tasks
	// ***********************************************************
	task automatic wrap_up;
		$display("Counts: %0d mismatches in %0d comparisons", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Look mid-cycle: at the rising edge pready may already show the next cycle
		for (int i = 0; i < 20; i++) begin
			@(negedge pclk);
			if (pready === 1'b1) begin
				q = prdata;
				e = pslverr;
				@(posedge pclk);
				{psel, penable} <= 2'b00;
				return;
			end
		end
		err_count++;
		wrap_up();
	endtask
	task automatic frame(input logic [MAG_W-1:0] spk, bg, input logic tr);
		src.send(spk, bg, tr);
		for (int i = 0; i < 8; i++) begin
			@(posedge pclk);
			#1;
			if (frame_done === 1'b1) return;
		end
		err_count++;
		wrap_up();
	endtask
	function automatic logic [18:0] part(input logic [1:0] bw, rt, input logic tr);
		logic [5:0] n;
		logic [9:0] s;
		case (bw)
			2'h0: begin n = tr ? (rt[1] ? 6'h14 : 6'h10) : (rt[1] ? 6'h13 : 6'h0D); s = 10'h0A0; end
			2'h1: begin n = tr ? (rt == 3 ? 6'h1C : 6'h14) : (rt == 3 ? 6'h14 : 6'h12); s = 10'h140; end
			default: begin n = tr ? 6'h20 : (rt == 3 ? 6'h18 : 6'h16); s = (rt == 3) ? 10'h280 : 10'h238; end
		endcase
		return {tr ? 3'h4 : 3'h1, n, s};
	endfunction
	// A lone spike over a zero floor is peaky in every sub-band; only its height decides the high count
	task automatic vote(input logic [MAG_W-1:0] spk, bg, input int times);
		logic cond;
		cond = (bg == 0) && (spk > 10);
		repeat (times) begin
			frame(spk, bg, 1'b0);
			if (cond) begin hv += (hv < 8); nv -= (nv > 0); end
			else begin hv -= (hv > 0); nv += (nv < 8); end
			harm = (nv < 5 && cond) || hv >= 5;
			chk(mode_harmonic, harm);
			apb(1'b0, OFS_STATUS, 32'h0, rd, er);
			chk(rd, {16'h0, nv, hv, 6'h0, harm, 1'b0});
		end
	endtask
	// ***********************************************************
	// Sequence
	// ***********************************************************
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_CTRL, 32'h0, rd, er);
		chk(rd, 32'h0);
		apb(1'b1, OFS_STATUS, 32'hFFFF, rd, er);
		apb(1'b0, OFS_STATUS, 32'h0, rd, er);
		chk(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0, rd, er);
		chk(rd, 32'h0);
		chk(er, 1'b1);
		for (int c = 0; c < 32; c++) begin
			apb(1'b1, OFS_CTRL, {28'h0, 4'(c)}, rd, er);
			frame(16'h0064, 16'h0000, c[4]);
			chk({mode_transient, mode_harmonic}, {c[4], !c[4] && c[1] && c[3]});
			pe = part(c[1:0], c[3:2], c[4]);
			chk({short_blocks, band_total, coef_total}, pe);
			apb(1'b0, OFS_BANDS, 32'h0, rd, er);
			chk(rd, {16'h0, pe[15:0]});
		end
		apb(1'b0, OFS_COUNTS, 32'h0, rd, er);
		chk(rd, 32'h0);
		// Four non-transient frames at the wide, high-rate settings voted harmonic above
		hv = 4'h4;
		nv = 4'h0;
		vote(16'h0064, 16'h0000, 5);
		vote(16'h0001, 16'h0001, 9);
		vote(16'h000B, 16'h0000, 4);
		vote(16'h000A, 16'h0000, 1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_STATUS, 32'h0, rd, er);
		chk(rd, 32'h0);
		wrap_up();
	end
endmodule // tb_hq_mode_classifier
